/* File: cct_count.v */
// cct_count.v: fixed divide-by-4 prescaler feeding the 16-bit free-running counter
// assumes: one clock, asynchronous active-low reset; nothing outside can load or pause it
`timescale 1ns/10ps
`include "cct_defines.vh"

module cct_count
(
    input  wire                  clk_i,
    input  wire                  nrst_i,
    output reg  [`CCT_CNT_W-1:0] count_o,
    output reg                   step_o
);

    reg [`CCT_PRE_W-1:0] presc;

    // no load or hold input exists, so software reads cannot disturb the sequence
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            presc   <= `CCT_PRE_RST;
            count_o <= `CCT_CNT_RST;
            step_o  <= 1'b0;
        end
        else
        begin
            presc  <= presc + `CCT_PRE_ONE;
            step_o <= (presc == `CCT_PRE_LAST);
            if (presc == `CCT_PRE_LAST)
            begin
                count_o <= count_o + `CCT_CNT_ONE;
            end
        end
    end

endmodule

/* File: cct_defines.vh */
// cct_defines.vh: register map, bit positions and reset values of the capture/compare timer
// assumes: included by bare name from every timer design file
`ifndef CCT_DEFINES_VH
`define CCT_DEFINES_VH

`define CCT_AW            8
`define CCT_DW            8

`define CCT_A_CTRL        8'h12
`define CCT_A_FLAGS       8'h13
`define CCT_A_CAP_HI      8'h14
`define CCT_A_CAP_LO      8'h15
`define CCT_A_CMP_HI      8'h16
`define CCT_A_CMP_LO      8'h17
`define CCT_A_CNT_HI      8'h18
`define CCT_A_CNT_LO      8'h19
`define CCT_A_ALT_HI      8'h1A
`define CCT_A_ALT_LO      8'h1B

`define CCT_B_CAP_IE      7
`define CCT_B_CMP_IE      6
`define CCT_B_OVF_IE      5
`define CCT_B_EDGE        1
`define CCT_B_LEVEL       0

`define CCT_B_CAP_F       7
`define CCT_B_CMP_F       6
`define CCT_B_OVF_F       5

`define CCT_CNT_W         16
`define CCT_PRE_W         2
`define CCT_PRE_LAST      2'h3
`define CCT_CNT_RST       16'hFFFC
`define CCT_CNT_ONE       16'h0001
`define CCT_CNT_ZERO      16'h0000
`define CCT_PRE_ONE       2'h1
`define CCT_PRE_RST       2'h0
`define CCT_BYTE_ZERO     8'h00

`endif

/* File: cct_pin_model.sv */
// cct_pin_model.sv: event source on the capture pin, load on the compare pin
// assumes: called from the bench right after a rising clock edge
`timescale 1ns/10ps
module cct_pin_model
(
    input  wire clk_i,
    input  wire compare_pin_i,
    output reg  capture_pin_o
);
    integer rises = 0;
    initial capture_pin_o = 1'b0;
    always @(posedge compare_pin_i) rises = rises + 1;
    // hold of at least two clocks so a synchronous edge detector sees the level
    task set_pin(input logic v, input integer hold);
        begin
            @(posedge clk_i);
            capture_pin_o <= v;
            repeat (hold) @(posedge clk_i);
        end
    endtask
endmodule

/* File: cct_timer.v */
// cct_timer.v: 16-bit capture/compare timer with byte-wide register port
// assumes: synchronous pin input, single clock, bus master never issues rd_i and wr_i together
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "cct_defines.vh"

module cct_timer
(
    input  wire                  clk_i,
    input  wire                  nrst_i,
    input  wire [`CCT_AW-1:0]    addr_i,
    input  wire [`CCT_DW-1:0]    wdata_i,
    input  wire                  wr_i,
    input  wire                  rd_i,
    output reg  [`CCT_DW-1:0]    rdata_o,
    input  wire                  capture_input_pin_i,
    output reg                   compare_output_pin_o,
    output wire                  irq_o
);

    function hit;
        input [`CCT_AW-1:0] a;
        input [`CCT_AW-1:0] sel;
        input               strobe;
        begin
            hit = strobe && (a == sel);
        end
    endfunction

    wire [`CCT_CNT_W-1:0] count;
    wire                  step;

    cct_count u_count
    (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .count_o (count),
        .step_o  (step)
    );

    // control bits
    reg                   capture_irq_enable;
    reg                   compare_irq_enable;
    reg                   overflow_irq_enable;
    reg                   match_output_level;
    reg                   capture_edge_select;

    // flags and values that reset leaves alone
    reg                   capture_flag;
    reg                   compare_flag;
    reg                   overflow_flag;
    reg  [`CCT_CNT_W-1:0] capture_value;
    reg  [`CCT_CNT_W-1:0] compare_value;
    reg                   pin_prev;

    // sequence state
    reg                   cap_armed;
    reg                   cmp_armed;
    reg                   ovf_armed;
    reg                   cap_block;
    reg                   cmp_block;
    reg                   cnt_held;
    reg  [`CCT_DW-1:0]    cnt_lo_hold;
    reg                   alt_held;
    reg  [`CCT_DW-1:0]    alt_lo_hold;

    wire wr_ctrl   = hit(addr_i, `CCT_A_CTRL, wr_i);
    wire rd_flags  = hit(addr_i, `CCT_A_FLAGS, rd_i);
    wire rd_cap_hi = hit(addr_i, `CCT_A_CAP_HI, rd_i);
    wire rd_cap_lo = hit(addr_i, `CCT_A_CAP_LO, rd_i);
    wire rd_cmp_lo = hit(addr_i, `CCT_A_CMP_LO, rd_i);
    wire wr_cmp_hi = hit(addr_i, `CCT_A_CMP_HI, wr_i);
    wire wr_cmp_lo = hit(addr_i, `CCT_A_CMP_LO, wr_i);
    wire rd_cnt_hi = hit(addr_i, `CCT_A_CNT_HI, rd_i);
    wire rd_cnt_lo = hit(addr_i, `CCT_A_CNT_LO, rd_i);
    wire rd_alt_hi = hit(addr_i, `CCT_A_ALT_HI, rd_i);
    wire rd_alt_lo = hit(addr_i, `CCT_A_ALT_LO, rd_i);

    // pin is taken as synchronous; one stage of history is enough for edges
    wire cap_edge = capture_edge_select ? (capture_input_pin_i && !pin_prev)
                                        : (!capture_input_pin_i && pin_prev);

    // count only changes on step, so the match is tested once per four clocks
    wire cmp_match = step && (count == compare_value) && !cmp_block;
    wire ovf_wrap  = step && (count == `CCT_CNT_ZERO);

    wire clr_cap = rd_cap_lo && cap_armed;
    wire clr_cmp = (rd_cmp_lo || wr_cmp_lo) && cmp_armed;
    wire clr_ovf = rd_cnt_lo && ovf_armed;

    wire [`CCT_DW-1:0] ctrl_view;
    wire [`CCT_DW-1:0] flags_view;

    assign ctrl_view = {capture_irq_enable, compare_irq_enable, overflow_irq_enable,
                        3'h0, capture_edge_select, match_output_level};
    assign flags_view = {capture_flag, compare_flag, overflow_flag, 5'h00};

    assign irq_o = (capture_flag && capture_irq_enable)
                 || (compare_flag && compare_irq_enable)
                 || (overflow_flag && overflow_irq_enable);

    // control bits that reset clears
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            capture_irq_enable  <= 1'b0;
            compare_irq_enable  <= 1'b0;
            overflow_irq_enable <= 1'b0;
            match_output_level  <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            capture_irq_enable  <= wdata_i[`CCT_B_CAP_IE];
            compare_irq_enable  <= wdata_i[`CCT_B_CMP_IE];
            overflow_irq_enable <= wdata_i[`CCT_B_OVF_IE];
            match_output_level  <= wdata_i[`CCT_B_LEVEL];
        end
    end

    // no reset here: edge select, flags and value registers survive reset;
    // after power-up they are unknown until software or an event sets them
    always @(posedge clk_i)
    begin
        pin_prev <= capture_input_pin_i;
        if (wr_ctrl)
        begin
            capture_edge_select <= wdata_i[`CCT_B_EDGE];
        end
        if (cap_edge && !cap_block)
        begin
            capture_value <= count;
        end
        if (wr_cmp_hi)
        begin
            compare_value[15:8] <= wdata_i;
        end
        if (wr_cmp_lo)
        begin
            compare_value[7:0] <= wdata_i;
        end
        // a set in the same cycle as a clear wins; status writes are ignored
        if (cap_edge)
        begin
            capture_flag <= 1'b1;
        end
        else if (clr_cap)
        begin
            capture_flag <= 1'b0;
        end
        if (cmp_match)
        begin
            compare_flag <= 1'b1;
        end
        else if (clr_cmp)
        begin
            compare_flag <= 1'b0;
        end
        if (ovf_wrap)
        begin
            overflow_flag <= 1'b1;
        end
        else if (clr_ovf)
        begin
            overflow_flag <= 1'b0;
        end
    end

    // compare pin: low from reset, then follows the level bit on each match
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            compare_output_pin_o <= 1'b0;
        end
        else if (cmp_match)
        begin
            compare_output_pin_o <= match_output_level;
        end
    end

    // clear sequences: a status read arms only the flags it saw set
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cap_armed <= 1'b0;
            cmp_armed <= 1'b0;
            ovf_armed <= 1'b0;
        end
        else if (rd_flags)
        begin
            cap_armed <= capture_flag;
            cmp_armed <= compare_flag;
            ovf_armed <= overflow_flag;
        end
        else
        begin
            if (rd_cap_lo)
            begin
                cap_armed <= 1'b0;
            end
            if (rd_cmp_lo || wr_cmp_lo)
            begin
                cmp_armed <= 1'b0;
            end
            if (rd_cnt_lo)
            begin
                ovf_armed <= 1'b0;
            end
        end
    end

    // high-then-low latches and inhibits
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cap_block   <= 1'b0;
            cmp_block   <= 1'b0;
            cnt_held    <= 1'b0;
            alt_held    <= 1'b0;
            cnt_lo_hold <= `CCT_BYTE_ZERO;
            alt_lo_hold <= `CCT_BYTE_ZERO;
        end
        else
        begin
            if (rd_cap_hi)
            begin
                cap_block <= 1'b1;
            end
            else if (rd_cap_lo)
            begin
                cap_block <= 1'b0;
            end
            if (wr_cmp_hi)
            begin
                cmp_block <= 1'b1;
            end
            else if (wr_cmp_lo)
            begin
                cmp_block <= 1'b0;
            end
            if (rd_cnt_hi)
            begin
                cnt_held    <= 1'b1;
                cnt_lo_hold <= count[7:0];
            end
            else if (rd_cnt_lo)
            begin
                cnt_held <= 1'b0;
            end
            if (rd_alt_hi)
            begin
                alt_held    <= 1'b1;
                alt_lo_hold <= count[7:0];
            end
            else if (rd_alt_lo)
            begin
                alt_held <= 1'b0;
            end
        end
    end

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= `CCT_BYTE_ZERO;
        end
        else if (!rd_i)
        begin
            rdata_o <= `CCT_BYTE_ZERO;
        end
        else
        begin
            case (addr_i)
                `CCT_A_CTRL:   rdata_o <= ctrl_view;
                `CCT_A_FLAGS:  rdata_o <= flags_view;
                `CCT_A_CAP_HI: rdata_o <= capture_value[15:8];
                `CCT_A_CAP_LO: rdata_o <= capture_value[7:0];
                `CCT_A_CMP_HI: rdata_o <= compare_value[15:8];
                `CCT_A_CMP_LO: rdata_o <= compare_value[7:0];
                `CCT_A_CNT_HI: rdata_o <= count[15:8];
                `CCT_A_CNT_LO: rdata_o <= cnt_held ? cnt_lo_hold : count[7:0];
                `CCT_A_ALT_HI: rdata_o <= count[15:8];
                `CCT_A_ALT_LO: rdata_o <= alt_held ? alt_lo_hold : count[7:0];
                default:       rdata_o <= `CCT_BYTE_ZERO;
            endcase
        end
    end

endmodule

/* File: cct_timer_sva.sv */
// cct_timer_sva.sv: port-level checker of the capture/compare timer
// assumes: bound to cct_timer; control writes mirrored from the bus
`timescale 1ns/10ps
`include "cct_defines.vh"
module cct_timer_chk
(
    input wire                  clk_i,
    input wire                  nrst_i,
    input wire [`CCT_AW-1:0]    addr_i,
    input wire [`CCT_DW-1:0]    wdata_i,
    input wire                  wr_i,
    input wire                  rd_i,
    input wire [`CCT_DW-1:0]    rdata_o,
    input wire                  capture_input_pin_i,
    input wire                  compare_output_pin_o,
    input wire                  irq_o
);
    reg [7:0] ctl;
    always @(posedge clk_i or negedge nrst_i)
        if (!nrst_i) ctl <= 8'h00;
        else if (wr_i && addr_i == `CCT_A_CTRL) ctl <= wdata_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    property p_unmap;
        rd_i && (addr_i < `CCT_A_CTRL || addr_i > `CCT_A_ALT_LO) |=> rdata_o == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_ctl_rd;
        rd_i && addr_i == `CCT_A_CTRL |=> rdata_o[7:5] == $past(ctl[7:5])
            && rdata_o[4:2] == 3'h0 && rdata_o[0] == $past(ctl[0]);
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    property p_flg_rd; rd_i && addr_i == `CCT_A_FLAGS |=> rdata_o[4:0] == 5'h00; endproperty
    a_flg_rd: assert property (p_flg_rd) else $error("status spare bits set");
    property p_irq_off; ctl[7:5] == 3'h0 |-> !irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("request with no enable");
    property p_pin_hi; $rose(compare_output_pin_o) |-> $past(ctl[0]); endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("pin rose with level 0");
    property p_pin_lo; $fell(compare_output_pin_o) |-> !$past(ctl[0]); endproperty
    a_pin_lo: assert property (p_pin_lo) else $error("pin fell with level 1");
    property p_ctl_wr;
        wr_i && addr_i == `CCT_A_CTRL ##1 rd_i && addr_i == `CCT_A_CTRL
            |=> rdata_o[7:5] == $past(wdata_i[7:5], 2);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");
endmodule
bind cct_timer cct_timer_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .capture_input_pin_i(capture_input_pin_i),
    .compare_output_pin_o(compare_output_pin_o), .irq_o(irq_o));

/* File: cct_timer_tb_top.sv */
// cct_timer_tb_top.sv: register-level tests of the capture/compare timer
// assumes: pin model drives the capture pin; 20 MHz clock
`timescale 1ns/10ps
`include "cct_defines.vh"
module cct_timer_tb_top;
    reg         clk_i, nrst_i, wr_i, rd_i;
    reg  [7:0]  addr_i, wdata_i, d, h;
    reg  [15:0] c1, c2, cp;
    wire [7:0]  rdata_o;
    wire        pin, irq_o, cap;
    integer     errors = 0, total_checks = 0;
    cct_timer uut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_pin_i(cap),
        .compare_output_pin_o(pin), .irq_o(irq_o));
    cct_pin_model pm (.clk_i(clk_i), .compare_pin_i(pin), .capture_pin_o(cap));
    initial
    begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end
    task wr(input [7:0] a, input [7:0] v);
        begin
            wr_i <= 1; addr_i <= a; wdata_i <= v;
            @(posedge clk_i);
            wr_i <= 0;
            // step off the edge so a following write never assigns wr_i twice in one step
            #1;
        end
    endtask
    task rd(input [7:0] a, output [7:0] v);
        begin
            rd_i <= 1; addr_i <= a;
            @(posedge clk_i);
            rd_i <= 0;
            #1 v = rdata_o;
        end
    endtask
    task rdc(input [7:0] a, output [15:0] v);
        begin
            rd(a, v[15:8]);
            rd(a + 8'h01, v[7:0]);
        end
    endtask
    task chk8(input [7:0] got, input [7:0] exp, input [7:0] m);
        begin
            total_checks++;
            if ((got & m) !== exp)
            begin
                errors++;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got & m, exp);
            end
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp}, 8'h01);
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        test_done;
    end
    initial
    begin
        nrst_i = 0; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1;
        @(posedge clk_i);
        rd(`CCT_A_CTRL, d); chk8(d, 8'h00, 8'hE1);
        chk1(pin, 0); chk1(irq_o, 0);
        wr(`CCT_A_CTRL, 8'h02); rd(`CCT_A_CTRL, d); chk8(d, 8'h02, 8'hFF);
        rd(8'h30, d); chk8(d, 8'h00, 8'hFF);
        $display("test control done");
        repeat (20) @(posedge clk_i);
        rd(`CCT_A_FLAGS, d); chk8(d, 8'h20, 8'h3F);
        rd(`CCT_A_ALT_LO, d); rd(`CCT_A_FLAGS, d); chk8(d, 8'h20, 8'h3F);
        rd(`CCT_A_CNT_LO, d); rd(`CCT_A_FLAGS, d); chk8(d, 8'h00, 8'h20);
        // 400 clocks between the two high-byte reads give 100 steps at any prescaler phase
        rdc(`CCT_A_CNT_HI, c1); repeat (398) @(posedge clk_i); rdc(`CCT_A_ALT_HI, c2);
        c2 = c2 - c1; chk8(c2[7:0], 8'h64, 8'hFF);
        $display("test counter done");
        rdc(`CCT_A_CNT_HI, c1); pm.set_pin(1, 3);
        rd(`CCT_A_FLAGS, d); chk8(d, 8'h80, 8'h80);
        rdc(`CCT_A_CAP_HI, cp); c2 = cp - c1; chk1(c2 < 16'h3, 1);
        rd(`CCT_A_FLAGS, d); chk8(d, 8'h00, 8'h80);
        rd(`CCT_A_CAP_HI, h); pm.set_pin(0, 3); pm.set_pin(1, 3);
        chk8(h, cp[15:8], 8'hFF);
        rd(`CCT_A_CAP_LO, d); chk8(d, cp[7:0], 8'hFF);
        wr(`CCT_A_CAP_LO, 8'h5A); rdc(`CCT_A_CAP_HI, c2); chk8(c2[7:0], cp[7:0], 8'hFF);
        wr(`CCT_A_CTRL, 8'h80); rd(`CCT_A_FLAGS, d); rd(`CCT_A_CAP_LO, d);
        chk1(irq_o, 0); pm.set_pin(0, 3); chk1(irq_o, 1);
        rd(`CCT_A_FLAGS, d); rd(`CCT_A_CAP_LO, d); chk1(irq_o, 0);
        pm.set_pin(1, 3); rd(`CCT_A_FLAGS, d); chk8(d, 8'h00, 8'h80);
        $display("test capture done");
        rdc(`CCT_A_CNT_HI, c1); c2 = c1 + 16'h20;
        wr(`CCT_A_CMP_HI, c2[15:8]); wr(`CCT_A_CMP_LO, c2[7:0]); wr(`CCT_A_CTRL, 8'h41);
        repeat (200) @(posedge clk_i);
        chk1(pin, 1); chk1(irq_o, 1);
        chk8(pm.rises[7:0], 8'h01, 8'hFF);
        wr(`CCT_A_FLAGS, 8'h00); rd(`CCT_A_FLAGS, d); chk8(d, 8'h40, 8'h40);
        rd(`CCT_A_CMP_LO, d); chk8(d, c2[7:0], 8'hFF);
        rd(`CCT_A_FLAGS, d); chk8(d, 8'h00, 8'h40); chk1(irq_o, 0);
        rdc(`CCT_A_CNT_HI, c1); c2 = c1 + 16'h20; wr(`CCT_A_CTRL, 8'h00);
        wr(`CCT_A_CMP_HI, c2[15:8]); wr(`CCT_A_CMP_LO, c2[7:0]); wr(`CCT_A_CMP_HI, c2[15:8]);
        repeat (200) @(posedge clk_i);
        chk1(pin, 1);
        rdc(`CCT_A_CNT_HI, c1); c2 = c1 + 16'h20;
        wr(`CCT_A_CMP_HI, c2[15:8]); wr(`CCT_A_CMP_LO, c2[7:0]);
        repeat (200) @(posedge clk_i);
        chk1(pin, 0);
        chk8(pm.rises[7:0], 8'h01, 8'hFF);
        $display("test compare done");
        test_done;
    end
endmodule
